// ===== logic/ppl_pkg.sv
// Package for the printer port pin logic: register map, fields, resets
// Overview of operation
// R1: Select output low is inverse of control bit 3.
// R2: Reset output follows control bit 2 directly; low initialises printer.
// R3: Line advance output low is inverse of control bit 1.
// R4: Data latch pulse output is inverse of control bit 0.
// R5: Status bit 7 reads inverse of the busy input.
// R6: Status bit 6 reads the received pulse input as is.
// R7: Status bit 5 reads the media empty input as is.
// R8: Status bit 4 reads the printer online input as is.
// R9: Status bit 3 reads the printer fault input as is.
// R10: In EPP mode pull the ready line low open-drain, else release it; code pulls it only while epp_cycle_active is also high.
// R11: Eight-line two-way port data bus carries bytes either direction.
// R12: Printer drives busy high when it cannot take data.
// R13: Printer drives received pulse low after taking a byte.
// R14: Printer raises media empty when out of paper, fault low on error.
// R15: All five status inputs pass two flip-flops before status reads.
package ppl_pkg;
  localparam logic [3:0] PPL_OFS_DATA = 4'h0;
  localparam logic [3:0] PPL_OFS_STATUS = 4'h4;
  localparam logic [3:0] PPL_OFS_CONTROL = 4'h8;
  localparam logic [3:0] PPL_OFS_IRQ_STAT = 4'hC;
  localparam logic [3:0] PPL_OFS_IRQ_MASK = 4'h0;
  localparam logic [5:0] PPL_ADDR_IRQ_MASK = 6'h10;
  // Control register fields
  localparam int PPL_CTL_STROBE = 0;
  localparam int PPL_CTL_AUTOFD = 1;
  localparam int PPL_CTL_INIT = 2;
  localparam int PPL_CTL_SELECT = 3;
  localparam int PPL_CTL_DIR = 5;
  localparam int PPL_CTL_EPP = 6;
  // Status register fields
  localparam int PPL_ST_FAULT = 3;
  localparam int PPL_ST_ONLINE = 4;
  localparam int PPL_ST_EMPTY = 5;
  localparam int PPL_ST_ACK = 6;
  localparam int PPL_ST_BUSY = 7;
  // Interrupt event bits
  localparam int PPL_EV_ACK = 0;
  localparam int PPL_EV_FAULT = 1;
  localparam int PPL_EV_EMPTY = 2;
  localparam logic [7:0] PPL_CTL_RESET = 8'h04;
  localparam logic [7:0] PPL_DATA_RESET = 8'h00;
  localparam logic [2:0] PPL_IRQ_RESET = 3'h0;
  localparam logic [1:0] PPL_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPL_RESP_SLVERR = 2'h2;

  // Raw printer status inputs
  typedef struct packed {
    logic busy;
    logic received;
    logic empty;
    logic online;
    logic fault;
  } ppl_status_t;

  // Printer control outputs
  typedef struct packed {
    logic choose_n;
    logic reset_n;
    logic advance_n;
    logic latch_n;
  } ppl_ctl_t;
endpackage

// ===== logic/ppl_sync.sv
// Two-stage synchroniser for printer status inputs
`timescale 1ns/100ps
module ppl_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  // Next stage values; first stage only feeds the second
  always_comb begin
    nxt_stage1 = async_in;
    nxt_stage2 = stage1_ff;
  end

  // Reset to zero; real levels arrive two edges after release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sync_out = stage2_ff;
endmodule

// ===== logic/ppl_top.sv
// Printer port pin logic with AXI4-Lite register slave
`timescale 1ns/100ps
module ppl_top
  import ppl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic printer_busy,
  input wire logic printer_received_pulse,
  input wire logic media_empty_flag,
  input wire logic printer_online,
  input wire logic printer_fault,
  output logic printer_choose_out,
  output logic printer_reset_out,
  output logic line_advance_out,
  output logic data_latch_pulse_out,
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe,
  input wire logic epp_cycle_active,
  output logic iochrdy_out,
  output logic iochrdy_oe,
  output logic irq
);
  ppl_status_t raw_st;
  ppl_status_t sync_st;
  logic [7:0] pd_sync;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] data_ff;
  logic [7:0] nxt_data;
  logic [2:0] irq_stat_ff;
  logic [2:0] nxt_irq_stat;
  logic [2:0] irq_mask_ff;
  logic [2:0] nxt_irq_mask;
  ppl_status_t prev_st_ff;
  logic aw_hold_ff;
  logic nxt_aw_hold;
  logic w_hold_ff;
  logic nxt_w_hold;
  logic [5:0] awaddr_ff;
  logic [5:0] nxt_awaddr;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;
  logic wr_go;
  logic [5:0] wr_addr;
  logic [31:0] wr_data;
  logic [2:0] events;
  logic [7:0] status_byte;

  // Word address decode shared by read and write paths; hi selects the 0x10 word group
  function automatic logic addr_hit(input logic [5:0] a, input logic [3:0] ofs, input logic hi);
    return (a[5:2] == {1'b0, hi, ofs[3:2]});
  endfunction

  assign raw_st = '{busy: printer_busy, received: printer_received_pulse,
                    empty: media_empty_flag, online: printer_online, fault: printer_fault};

  // Pin levels are asynchronous, so both inputs groups pass two stages
  ppl_sync #(.WIDTH(5)) u_st_sync ( // R15
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(raw_st),
    .sync_out(sync_st)
  );
  ppl_sync #(.WIDTH(8)) u_pd_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(port_data_lines_in),
    .sync_out(pd_sync)
  );

  // Status byte as software sees it
  always_comb begin
    status_byte = 8'h00;
    status_byte[PPL_ST_BUSY] = ~sync_st.busy; // R5
    status_byte[PPL_ST_ACK] = sync_st.received; // R6
    status_byte[PPL_ST_EMPTY] = sync_st.empty; // R7
    status_byte[PPL_ST_ONLINE] = sync_st.online; // R8
    status_byte[PPL_ST_FAULT] = sync_st.fault; // R9
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  assign wr_go = (aw_hold_ff | (s_axi_awvalid & s_axi_awready)) &
                 (w_hold_ff | (s_axi_wvalid & s_axi_wready)) & ~bvalid_ff;

  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_hold = 1'b1;
      nxt_wdata = s_axi_wdata;
    end
    if (wr_go) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (addr_hit(wr_addr, PPL_OFS_DATA, 1'b0) || addr_hit(wr_addr, PPL_OFS_STATUS, 1'b0) ||
                   addr_hit(wr_addr, PPL_OFS_CONTROL, 1'b0) || addr_hit(wr_addr, PPL_OFS_IRQ_STAT, 1'b0) ||
                   addr_hit(wr_addr, PPL_OFS_IRQ_MASK, 1'b1)) ? PPL_RESP_OKAY : PPL_RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Register writes; status register ignores writes
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_data = data_ff;
    nxt_irq_mask = irq_mask_ff;
    if (wr_go && wr_data_lane_ok(s_axi_wstrb, w_hold_ff)) begin
      if (addr_hit(wr_addr, PPL_OFS_CONTROL, 1'b0)) begin
        nxt_ctl = wr_data[7:0];
      end
      if (addr_hit(wr_addr, PPL_OFS_DATA, 1'b0)) begin
        nxt_data = wr_data[7:0];
      end
      if (addr_hit(wr_addr, PPL_OFS_IRQ_MASK, 1'b1)) begin
        nxt_irq_mask = wr_data[2:0];
      end
    end
  end

  // Byte lane 0 must be enabled; strobes held with data are not kept, so held data counts as full
  function automatic logic wr_data_lane_ok(input logic [3:0] strb, input logic held);
    return held | strb[0];
  endfunction

  // Events: falling received pulse, falling fault, rising media empty
  assign events[PPL_EV_ACK] = prev_st_ff.received & ~sync_st.received;
  assign events[PPL_EV_FAULT] = prev_st_ff.fault & ~sync_st.fault;
  assign events[PPL_EV_EMPTY] = ~prev_st_ff.empty & sync_st.empty;

  // Sticky status; a new event wins over a write-one clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_go && wr_data_lane_ok(s_axi_wstrb, w_hold_ff) && addr_hit(wr_addr, PPL_OFS_IRQ_STAT, 1'b0)) begin
      nxt_irq_stat = irq_stat_ff & ~wr_data[2:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
  end

  // Read channel: one read at a time, answered one cycle after address
  assign s_axi_arready = ~rvalid_ff;
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = PPL_RESP_OKAY;
      nxt_rdata = 32'h00000000;
      if (addr_hit(s_axi_araddr, PPL_OFS_DATA, 1'b0)) begin
        nxt_rdata[7:0] = ctl_ff[PPL_CTL_DIR] ? pd_sync : data_ff; // R11
      end else if (addr_hit(s_axi_araddr, PPL_OFS_STATUS, 1'b0)) begin
        nxt_rdata[7:0] = status_byte;
      end else if (addr_hit(s_axi_araddr, PPL_OFS_CONTROL, 1'b0)) begin
        nxt_rdata[7:0] = ctl_ff;
      end else if (addr_hit(s_axi_araddr, PPL_OFS_IRQ_STAT, 1'b0)) begin
        nxt_rdata[2:0] = irq_stat_ff;
      end else if (addr_hit(s_axi_araddr, PPL_OFS_IRQ_MASK, 1'b1)) begin
        nxt_rdata[2:0] = irq_mask_ff;
      end else begin
        nxt_rresp = PPL_RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // All state registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_ff <= PPL_CTL_RESET;
      data_ff <= PPL_DATA_RESET;
      irq_stat_ff <= PPL_IRQ_RESET;
      irq_mask_ff <= PPL_IRQ_RESET;
      prev_st_ff <= '0;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff <= 32'h00000000;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end else begin
      ctl_ff <= nxt_ctl;
      data_ff <= nxt_data;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      prev_st_ff <= sync_st;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Printer control pins straight from control register flops
  assign printer_choose_out = ~ctl_ff[PPL_CTL_SELECT]; // R1
  assign printer_reset_out = ctl_ff[PPL_CTL_INIT]; // R2
  assign line_advance_out = ~ctl_ff[PPL_CTL_AUTOFD]; // R3
  assign data_latch_pulse_out = ~ctl_ff[PPL_CTL_STROBE]; // R4

  // Data bus: drive unless software turned the port around for input
  assign port_data_lines_out = data_ff; // R11
  assign port_data_lines_oe = ~ctl_ff[PPL_CTL_DIR]; // R11

  // Open drain: only ever drives low, so output is constant zero
  assign iochrdy_out = 1'b0;
  assign iochrdy_oe = ctl_ff[PPL_CTL_EPP] & epp_cycle_active; // R10

  assign irq = |(irq_stat_ff & irq_mask_ff);

  select_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && addr_hit(wr_addr, PPL_OFS_CONTROL, 1'b0) && wr_data_lane_ok(s_axi_wstrb, w_hold_ff)
    |=> printer_choose_out == ~$past(wr_data[PPL_CTL_SELECT])) // R1
    else $error("select pin does not follow control bit");
  reset_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && addr_hit(wr_addr, PPL_OFS_CONTROL, 1'b0) && wr_data_lane_ok(s_axi_wstrb, w_hold_ff)
    |=> printer_reset_out == $past(wr_data[PPL_CTL_INIT])) // R2
    else $error("reset pin does not follow control bit");
  advance_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    line_advance_out != ctl_ff[PPL_CTL_AUTOFD]) // R3
    else $error("line advance pin not inverted");
  latch_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && addr_hit(wr_addr, PPL_OFS_CONTROL, 1'b0) && wr_data_lane_ok(s_axi_wstrb, w_hold_ff)
    |=> data_latch_pulse_out == ~$past(wr_data[PPL_CTL_STROBE])) // R4
    else $error("latch pulse not set by control write");
  // Sampled pin two edges back was taken while the synchroniser still sat in reset
  busy_path_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##2 ($past(rst, 2) || status_byte[PPL_ST_BUSY] == ~$past(printer_busy, 2))) // R5 R15
    else $error("busy status wrong or not two stages late");
  ack_path_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##2 ($past(rst, 2) || status_byte[PPL_ST_ACK] == $past(printer_received_pulse, 2))) // R6
    else $error("received status wrong");
  empty_path_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##2 ($past(rst, 2) || status_byte[PPL_ST_EMPTY] == $past(media_empty_flag, 2))) // R7
    else $error("media empty status wrong");
  online_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##2 ($past(rst, 2) || {status_byte[PPL_ST_ONLINE], status_byte[PPL_ST_FAULT]} ==
    {$past(printer_online, 2), $past(printer_fault, 2)})) // R8 R9
    else $error("online or fault status wrong");
  ready_pull_a: assert property (@(posedge clk_sys) disable iff (rst)
    iochrdy_oe |-> (ctl_ff[PPL_CTL_EPP] && iochrdy_out == 1'b0)) // R10
    else $error("ready line pulled outside EPP mode");
  data_dir_a: assert property (@(posedge clk_sys) disable iff (rst)
    port_data_lines_oe |-> port_data_lines_out == data_ff && !ctl_ff[PPL_CTL_DIR]) // R11
    else $error("data bus driven in input direction");
  write_resp_c: cover property (@(posedge clk_sys) disable iff (rst) wr_go ##[1:4] s_axi_bvalid && s_axi_bready);
  read_resp_c: cover property (@(posedge clk_sys) disable iff (rst) s_axi_arvalid ##1 s_axi_rvalid);
  irq_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
  epp_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(iochrdy_oe));
endmodule

// ===== sim/ppl_printer_model.sv
// Behavioural printer on the far side of the port
`timescale 1ns/100ps
module ppl_printer_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic strobe_n,
  input wire logic [7:0] bus_level,
  input wire logic [7:0] hold_cycles,
  input wire logic paper_out,
  input wire logic error_on,
  input wire logic power_on,
  output logic busy,
  output logic ack_n,
  output logic empty,
  output logic online,
  output logic fault_n,
  output logic [7:0] got_byte
);
  logic strobe_q;
  logic [7:0] cnt;
  // Static lines follow the commanded printer state
  assign empty = paper_out;
  assign fault_n = ~error_on;
  assign online = power_on;
  // Take a byte on the strobe fall, stay busy a while, then acknowledge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b1;
      busy <= 1'b0;
      ack_n <= 1'b1;
      cnt <= 8'h00;
      got_byte <= 8'h00;
    end else begin
      strobe_q <= strobe_n;
      ack_n <= 1'b1;
      if (strobe_q && !strobe_n && !busy) begin
        got_byte <= bus_level;
        busy <= 1'b1;
        cnt <= hold_cycles;
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy <= 1'b0;
        ack_n <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the printer port pin logic
`timescale 1ns/100ps
module tb_top;
  import ppl_pkg::*;
  localparam logic [5:0] A_DAT = {2'h0, PPL_OFS_DATA};
  localparam logic [5:0] A_ST = {2'h0, PPL_OFS_STATUS};
  localparam logic [5:0] A_CTL = {2'h0, PPL_OFS_CONTROL};
  localparam logic [5:0] A_IST = {2'h0, PPL_OFS_IRQ_STAT};
  localparam logic [5:0] A_MSK = PPL_ADDR_IRQ_MASK;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic printer_busy, printer_received_pulse, media_empty_flag, printer_online, printer_fault;
  logic printer_choose_out, printer_reset_out, line_advance_out, data_latch_pulse_out;
  logic [7:0] port_data_lines_in, port_data_lines_out, got_byte, reply_byte = 8'h00, hold_cycles = 8'h02;
  logic port_data_lines_oe, iochrdy_out, iochrdy_oe, irq, iochrdy_line;
  logic epp_cycle_active = 1'b0, paper_out = 1'b0, error_on = 1'b0, power_on = 1'b1;
  int miscompares = 0, n_tests = 0;
  // Wire levels: data bus from whoever drives, ready line pulled up
  assign port_data_lines_in = port_data_lines_oe ? port_data_lines_out : reply_byte;
  assign iochrdy_line = iochrdy_oe ? iochrdy_out : 1'b1;
  always #2 clk_sys = ~clk_sys;
  ppl_top i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .printer_busy,
    .printer_received_pulse, .media_empty_flag, .printer_online, .printer_fault, .printer_choose_out,
    .printer_reset_out, .line_advance_out, .data_latch_pulse_out, .port_data_lines_in, .port_data_lines_out,
    .port_data_lines_oe, .epp_cycle_active, .iochrdy_out, .iochrdy_oe, .irq);
  ppl_printer_model i_prn (.clk_sys, .rst, .strobe_n(data_latch_pulse_out), .bus_level(port_data_lines_in),
    .hold_cycles, .paper_out, .error_on, .power_on, .busy(printer_busy), .ack_n(printer_received_pulse),
    .empty(media_empty_flag), .online(printer_online), .fault_n(printer_fault), .got_byte);
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask
  // Bus write; address and data released separately as each is taken
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  // Bus read
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wr_ok(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, PPL_RESP_OKAY});
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, PPL_RESP_OKAY});
  endtask
  function automatic logic [31:0] pins();
    return {28'h0, printer_choose_out, printer_reset_out, line_advance_out, data_latch_pulse_out};
  endfunction
  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Pin and register values straight out of reset
  task automatic t_reset();
    chk(pins(), 32'h0F);
    chk({21'h0, port_data_lines_oe, iochrdy_oe, irq, port_data_lines_out}, {21'h0, 3'h4, 8'h00});
    rd_chk(A_CTL, 32'h04);
    rd_chk(A_DAT, 32'h00);
    rd_chk(A_IST, 32'h00);
    rd_chk(A_MSK, 32'h00);
  endtask
  // Every combination of the four control bits reaches the pins
  task automatic t_ctl();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      wr_ok(A_CTL, {28'h0, v});
      chk(pins(), {28'h0, ~v[3], v[2], ~v[1], ~v[0]});
      rd_chk(A_CTL, {28'h0, v});
    end
    wr_ok(A_CTL, 32'h04);
  endtask
  // Every combination of paper, fault and power shows in status
  task automatic t_status();
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      paper_out <= v[0];
      error_on <= v[1];
      power_on <= v[2];
      wait_cy(8);
      rd_chk(A_ST, {24'h0, 2'h3, v[0], v[2], ~v[1], 3'h0});
    end
    paper_out <= 1'b0;
    error_on <= 1'b0;
    wait_cy(8);
  endtask
  // One byte to the printer; long holds are also seen busy in status
  task automatic t_print(input logic [7:0] b, input logic [7:0] h);
    int n;
    hold_cycles <= h;
    wr_ok(A_IST, 32'h07);
    wr_ok(A_DAT, {24'h0, b});
    wr_ok(A_CTL, 32'h05);
    wr_ok(A_CTL, 32'h04);
    if (h > 8'h1E) rd_chk(A_ST, 32'h58);
    n = 0;
    while (printer_busy && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, n < 300}, 32'h1);
    wait_cy(6);
    chk({24'h0, got_byte}, {24'h0, b});
    rd_chk(A_ST, 32'hD8);
    rd_chk(A_IST, 32'h01);
  endtask
  // Fault and paper events, masking and write-one clearing
  task automatic t_irq();
    wr_ok(A_IST, 32'h07);
    paper_out <= 1'b1;
    error_on <= 1'b1;
    wait_cy(8);
    rd_chk(A_IST, 32'h06);
    chk({31'h0, irq}, 32'h0);
    wr_ok(A_MSK, 32'h04);
    wait_cy(2);
    chk({31'h0, irq}, 32'h1);
    wr_ok(A_MSK, 32'h01);
    wait_cy(2);
    chk({31'h0, irq}, 32'h0);
    wr_ok(A_MSK, 32'h06);
    wr_ok(A_IST, 32'h06);
    wait_cy(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(A_IST, 32'h00);
    paper_out <= 1'b0;
    error_on <= 1'b0;
    wait_cy(8);
    wr_ok(A_IST, 32'h07);
  endtask
  // Data bus turned around, then driven again
  task automatic t_dir();
    reply_byte <= 8'h3C;
    wr_ok(A_CTL, 32'h24);
    chk({31'h0, port_data_lines_oe}, 32'h0);
    rd_chk(A_DAT, 32'h3C);
    wr_ok(A_CTL, 32'h04);
    wr_ok(A_DAT, 32'h5A);
    chk({23'h0, port_data_lines_oe, port_data_lines_in}, 32'h15A);
    rd_chk(A_DAT, 32'h5A);
  endtask
  // Ready line pulled only with EPP mode and a live command together
  task automatic t_epp();
    for (int i = 0; i < 4; i++) begin
      wr_ok(A_CTL, {25'h0, i[1], 6'h04});
      epp_cycle_active <= i[0];
      wait_cy(2);
      chk({30'h0, iochrdy_oe, iochrdy_line}, {30'h0, i[1] & i[0], ~(i[1] & i[0])});
    end
    epp_cycle_active <= 1'b0;
    wr_ok(A_CTL, 32'h04);
  endtask
  // Unmapped places refused, status not writable
  task automatic t_bad();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(6'h14, 32'h0B, r);
    chk({30'h0, r}, {30'h0, PPL_RESP_SLVERR});
    axi_rd(6'h3C, d, r);
    chk({30'h0, r}, {30'h0, PPL_RESP_SLVERR});
    axi_wr(A_ST, 32'hFF, r);
    chk({30'h0, r}, {30'h0, PPL_RESP_OKAY});
    rd_chk(A_ST, 32'hD8);
    chk(pins(), 32'h0F);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    wait_cy(6);
    rst <= 1'b0;
    t_reset();
    t_ctl();
    t_status();
    t_print(8'hA5, 8'h28);
    t_print(8'h3C, 8'h00);
    t_irq();
    t_dir();
    t_epp();
    t_bad();
    give_verdict();
  end
  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #80000;
    miscompares++;
    give_verdict();
  end
endmodule
